/* design/mhr_sequencer.v */
// Machine home return sequencer for one positioning axis
// Notes on behaviour
// [R01] Methods one to five ignore stored addresses
// [R02] Method six takes absolute detector address
// [R03] Start moves at configured speed and direction
// [R04] Home address loads both feed monitors
// [R05] Home absolute monitor loaded, then tracks changes
// [R06] Six methods chosen by method select; only methods 1, 2 and 6 are built, codes 3 to 5 raise an error
// [R07] Dog rising edge starts decel to creep
// [R08] Dog method stops on zero after dog off
// [R09] No zero passed: stop, error 210
// [R10] Method two: stop, reverse one turn
// [R11] Then return at speed, stop on zero
// [R12] User enables retry when home side varies
// [R13] Zero point is first zero-signal rising edge
// [R14] Host starts with number 9001 plus start
// [R15] Completion clears request, sets complete flag
`include "mhr_map.vh"
module mhr_sequencer #(
  parameter AW = 32                       // Address width
) (
  input  wire          mclk,              // 20 MHz clock
  input  wire          rst,               // Async reset, high
  input  wire          clk_en,            // Freezes state when low
  input  wire          pos_start,         // Positioning start, same domain
  input  wire [15:0]   start_number_command, // Requested start number
  input  wire [2:0]    home_method_select,   // Home method 1..6
  input  wire          home_dir_setting,     // Home direction, 1 = reverse
  input  wire [AW-1:0] home_address_setting, // Home address
  input  wire [31:0]   home_return_speed,    // Fast speed
  input  wire [31:0]   creep_speed_setting,  // Creep speed
  input  wire [AW-1:0] abs_detect_address,   // Servo absolute address
  input  wire [AW-1:0] addr_change,          // Address shift applied
  input  wire          addr_change_stb,      // Shift strobe, same domain
  input  wire          servo_stopped,        // Servo reports standstill
  input  wire          turn_done,            // Reverse turn finished
  input  wire          dog_pin,              // Near-point dog, async
  input  wire          zero_pin,             // Zero-point signal, async
  output reg  [1:0]    move_cmd,             // Motion command code
  output reg           move_dir,             // Motion direction
  output reg  [31:0]   move_speed,           // Target speed
  output reg           reverse_turn,         // Request one-turn reverse
  output reg  [AW-1:0] current_feed_monitor, // Current feed value
  output reg  [AW-1:0] machine_feed_monitor, // Machine feed value
  output reg  [AW-1:0] home_absolute_position_monitor, // Home position
  output reg  [15:0]   axis_status_word,     // Status flags
  output reg  [15:0]   error_code,           // Last error code
  output reg           busy                  // Home return running
);

  // Sequencer states
  localparam S_IDLE  = 3'h0;
  localparam S_FAST  = 3'h1;
  localparam S_CREEP = 3'h2;
  localparam S_SEEK  = 3'h3;
  localparam S_HALT  = 3'h4;
  localparam S_REV   = 3'h5;
  localparam S_DONE  = 3'h6;
  localparam S_ERR   = 3'h7;

  reg [2:0] state;        // Current state
  reg       dog_s1;       // Dog sync stage 1
  reg       dog_s2;       // Dog sync stage 2
  reg       dog_q;        // Dog previous value
  reg       zero_s1;      // Zero sync stage 1
  reg       zero_s2;      // Zero sync stage 2
  reg       zero_q;       // Zero previous value
  reg       zero_seen;    // Zero passed since start
  reg       recovered;    // Reverse turn already done
  reg       halt_err;     // Halt ends in error, not reverse

  wire dog_rise  = dog_s2 & ~dog_q;   // Dog off to on
  wire dog_fall  = ~dog_s2 & dog_q;   // Dog on to off
  wire zero_rise = zero_s2 & ~zero_q; // Zero off to on [R13]

  // Method is a searching dog method
  function is_dog;
    input [2:0] m;
    begin
      is_dog = (m == `MHR_METH_DOG) || (m == `MHR_METH_DOG2);
    end
  endfunction

  // Two-flop synchronisers for the pins; stage 1 feeds stage 2 only
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      dog_s1  <= 1'b0;
      dog_s2  <= 1'b0;
      dog_q   <= 1'b0;
      zero_s1 <= 1'b0;
      zero_s2 <= 1'b0;
      zero_q  <= 1'b0;
    end else if (clk_en) begin
      dog_s1  <= dog_pin;
      dog_s2  <= dog_s1;
      dog_q   <= dog_s2;
      zero_s1 <= zero_pin;
      zero_s2 <= zero_s1;
      zero_q  <= zero_s2;
    end
  end

  // Main sequence; counting methods are not built and refuse to start
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state        <= S_IDLE;
      move_cmd     <= `MHR_MV_STOP;
      move_dir     <= 1'b0;
      move_speed   <= 32'h0000_0000;
      reverse_turn <= 1'b0;
      current_feed_monitor <= {AW{1'b0}};
      machine_feed_monitor <= {AW{1'b0}};
      home_absolute_position_monitor <= {AW{1'b0}};
      axis_status_word <= `MHR_RST_STATUS;
      error_code   <= `MHR_ERR_NONE;
      busy         <= 1'b0;
      zero_seen    <= 1'b0;
      recovered    <= 1'b0;
      halt_err     <= 1'b0;
    end else if (clk_en) begin
      // Keep home monitor pointing at home after address shifts [R05]
      if (addr_change_stb && state != S_DONE)
        home_absolute_position_monitor <=
          home_absolute_position_monitor + addr_change;
      // Note a zero point seen while searching
      if (zero_rise && busy)
        zero_seen <= 1'b1;
      case (state)
        S_IDLE: begin
          reverse_turn <= 1'b0;
          // Host starts with home start number and start pulse [R14]
          if (pos_start && start_number_command == `MHR_START_HOME) begin
            error_code <= `MHR_ERR_NONE;
            zero_seen  <= 1'b0;
            recovered  <= 1'b0;
            if (home_method_select == `MHR_METH_DATA) begin
              state <= S_DONE;                        // [R02]
            end else if (is_dog(home_method_select)) begin
              // Mechanical search only, no stored address used [R01]
              busy       <= 1'b1;
              move_cmd   <= `MHR_MV_FAST;             // [R03]
              move_dir   <= home_dir_setting;         // [R03]
              move_speed <= home_return_speed;        // [R03]
              state      <= S_FAST;                   // [R06]
            end else begin
              // Unsupported method codes raise an error [R06]
              error_code <= `MHR_ERR_METHOD;
            end
          end
        end
        S_FAST: begin
          if (dog_rise) begin
            move_cmd   <= `MHR_MV_CREEP;              // [R07]
            move_speed <= creep_speed_setting;        // [R07]
            state      <= S_CREEP;
          end
        end
        S_CREEP: begin
          if (dog_fall) begin
            if (zero_seen || recovered) begin
              state <= S_SEEK;                        // [R08] [R11]
            end else begin
              // No zero yet: decelerate to standstill [R09] [R10]
              move_cmd <= `MHR_MV_DECEL;
              halt_err <= (home_method_select == `MHR_METH_DOG);
              state    <= S_HALT;
            end
          end
        end
        S_SEEK: begin
          if (zero_rise) begin
            move_cmd   <= `MHR_MV_STOP;               // [R08] [R13]
            move_speed <= 32'h0000_0000;
            state      <= S_DONE;
          end
        end
        S_HALT: begin
          if (servo_stopped) begin
            move_cmd   <= `MHR_MV_STOP;
            move_speed <= 32'h0000_0000;
            if (halt_err) begin
              error_code <= `MHR_ERR_NO_ZERO;         // [R09]
              state      <= S_ERR;
            end else begin
              reverse_turn <= 1'b1;                   // [R10]
              move_dir     <= ~home_dir_setting;      // [R10]
              state        <= S_REV;
            end
          end
        end
        S_REV: begin
          if (turn_done) begin
            // Return toward home at home speed [R11]
            reverse_turn <= 1'b0;
            recovered    <= 1'b1;
            move_dir     <= home_dir_setting;
            move_cmd     <= `MHR_MV_FAST;
            move_speed   <= home_return_speed;
            state        <= S_FAST;
          end
        end
        S_DONE: begin
          // Load home into monitors once stopped [R04] [R05]
          if (home_method_select == `MHR_METH_DATA) begin
            current_feed_monitor <= abs_detect_address;           // [R02]
            machine_feed_monitor <= abs_detect_address;
            home_absolute_position_monitor <= abs_detect_address;
          end else begin
            current_feed_monitor <= home_address_setting;         // [R04]
            machine_feed_monitor <= home_address_setting;         // [R04]
            home_absolute_position_monitor <= home_address_setting; // [R05]
          end
          axis_status_word[`MHR_ST_REQ_BIT]  <= 1'b0;             // [R15]
          axis_status_word[`MHR_ST_DONE_BIT] <= 1'b1;             // [R15]
          busy  <= 1'b0;
          state <= S_IDLE;
        end
        S_ERR: begin
          // Error ends the run; status word flags are left unchanged
          busy  <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

/* design/mhr_map.vh */
// Constants for the machine home return sequencer
`ifndef MHR_MAP_VH
`define MHR_MAP_VH
// Home method codes
`define MHR_METH_DOG      3'h1
`define MHR_METH_DOG2     3'h2
`define MHR_METH_CNT1     3'h3
`define MHR_METH_CNT2     3'h4
`define MHR_METH_CNT3     3'h5
`define MHR_METH_DATA     3'h6
// Start number for machine home return
`define MHR_START_HOME    16'h2329
// Error codes
`define MHR_ERR_NONE      16'h0000
`define MHR_ERR_NO_ZERO   16'h00d2
`define MHR_ERR_METHOD    16'h00d3
// Status word bit positions
`define MHR_ST_REQ_BIT    3
`define MHR_ST_DONE_BIT   4
// Motion command codes
`define MHR_MV_STOP       2'h0
`define MHR_MV_FAST       2'h1
`define MHR_MV_CREEP      2'h2
`define MHR_MV_DECEL      2'h3
// Reset values
`define MHR_RST_STATUS    16'h0008
`endif

/* dv/mhr_chk.sv */
// Port checker for the home return sequencer
`include "mhr_map.vh"
module mhr_chk #(parameter AW = 32) (
  input wire mclk, rst, clk_en, pos_start, dog_pin, zero_pin, // Inputs
  input wire servo_stopped, addr_change_stb, busy, reverse_turn, // Flags
  input wire [15:0] start_number_command, axis_status_word, error_code,
  input wire [2:0] home_method_select, // Method
  input wire [1:0] move_cmd, // Motion code
  input wire [31:0] move_speed, home_return_speed, creep_speed_setting,
  input wire [AW-1:0] home_address_setting, addr_change, // Settings
  input wire [AW-1:0] current_feed_monitor, machine_feed_monitor, // Feeds
  input wire [AW-1:0] home_absolute_position_monitor // Home monitor
);
  timeunit 1ns;
  timeprecision 1ps;
  // Start that the sequencer must take from idle
  wire go = !busy && clk_en && pos_start &&
            start_number_command == `MHR_START_HOME;
  wire m1 = home_method_select == `MHR_METH_DOG; // Plain dog method
  wire m2 = home_method_select == `MHR_METH_DOG2; // Reverse-turn method
  // Clean end of a dog run; the falling edge is taken inside each property
  wire okc = error_code == `MHR_ERR_NONE && (m1 || m2);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_start; go && (m1 || m2) |=> busy &&
    move_cmd == `MHR_MV_FAST && move_speed == home_return_speed; endproperty
  a_start: assert property (p_start) else $error("start move wrong");
  property p_feed; $fell(busy) && okc |->
    current_feed_monitor == home_address_setting &&
    machine_feed_monitor == home_address_setting; endproperty
  a_feed: assert property (p_feed) else $error("feed monitors wrong");
  property p_habs; $fell(busy) && okc |->
    home_absolute_position_monitor == home_address_setting; endproperty
  a_habs: assert property (p_habs) else $error("home monitor wrong");
  property p_stat; $fell(busy) && okc |->
    axis_status_word[4] && !axis_status_word[3];
  endproperty
  a_stat: assert property (p_stat) else $error("status flags wrong");
  property p_trk; !busy && clk_en && addr_change_stb && axis_status_word[4]
    |=> home_absolute_position_monitor ==
    $past(home_absolute_position_monitor) + $past(addr_change); endproperty
  a_trk: assert property (p_trk) else $error("home tracking wrong");
  property p_creep; busy && move_cmd == `MHR_MV_FAST && $rose(dog_pin) |->
    ##[1:6] move_cmd == `MHR_MV_CREEP && move_speed == creep_speed_setting;
  endproperty
  a_creep: assert property (p_creep) else $error("no creep");
  property p_zero; busy && move_cmd == `MHR_MV_CREEP && !dog_pin &&
    $rose(zero_pin) |-> ##[1:6] move_cmd == `MHR_MV_STOP; endproperty
  a_zero: assert property (p_zero) else $error("no stop on zero");
  property p_e210; busy && m1 && move_cmd == `MHR_MV_DECEL && servo_stopped
    |-> ##[1:3] error_code == `MHR_ERR_NO_ZERO; endproperty
  a_e210: assert property (p_e210) else $error("no error 210");
  property p_rev; busy && m2 && move_cmd == `MHR_MV_DECEL && servo_stopped
    |-> ##[1:3] reverse_turn; endproperty
  a_rev: assert property (p_rev) else $error("no reverse turn");
  property p_bad; go && home_method_select inside {3, 4, 5} |->
    ##[1:3] error_code == `MHR_ERR_METHOD && !busy; endproperty
  a_bad: assert property (p_bad) else $error("bad method taken");
endmodule
bind mhr_sequencer mhr_chk #(.AW(AW)) u_chk (.*);

/* dv/mhr_servo.sv */
// Behavioural servo amplifier answering stop and turn requests
module mhr_servo #(parameter int DLY = 4) (
  input  wire logic       mclk,          // System clock
  input  wire logic       rst,           // Reset, high
  input  wire logic [1:0] move_cmd,      // Motion command
  input  wire logic       reverse_turn,  // One-turn request
  output logic            servo_stopped, // Standstill report
  output logic            turn_done      // Turn finished
);
  timeunit 1ns;
  timeprecision 1ps;
  int sc; // Cycles spent stopping
  int tc; // Cycles spent turning
  // A real drive settles late, so both answers lag by DLY cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sc <= 0;
      tc <= 0;
    end else begin
      sc <= (move_cmd[0] == move_cmd[1]) ? sc + 1 : 0;
      tc <= reverse_turn ? tc + 1 : 0;
    end
  end
  assign servo_stopped = sc >= DLY;
  assign turn_done = tc >= DLY;
endmodule

/* dv/machine_home_return_sequencer_tb_top.sv */
// Testbench for the home return sequencer
`include "mhr_map.vh"
module machine_home_return_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, clk_en = 1, pos_start = 0, home_dir_setting = 1;
  logic addr_change_stb = 0, dog_pin = 0, zero_pin = 0;
  logic [15:0] start_number_command = `MHR_START_HOME;
  logic [2:0] home_method_select = `MHR_METH_DOG;
  logic [31:0] home_address_setting = 32'h1234, home_return_speed = 32'h400;
  logic [31:0] creep_speed_setting = 32'h20, abs_detect_address = 32'h5000;
  logic [31:0] addr_change = 32'h10;
  wire servo_stopped, turn_done, reverse_turn, busy, move_dir;
  wire [1:0] move_cmd;
  wire [31:0] move_speed, current_feed_monitor, machine_feed_monitor;
  wire [31:0] home_absolute_position_monitor;
  wire [15:0] axis_status_word, error_code;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  mhr_sequencer #(.AW(32)) u_dut (.*);
  mhr_servo #(.DLY(4)) u_srv (.*);
  initial forever #25 mclk = ~mclk;
  // Cuts a hung run short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      $display("Error timeout expected done seen hung");
      final_report;
    end
  end
  task tick(input int n); repeat (n) @(posedge mclk); #5; endtask
  task chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task go(input logic [2:0] m);
    home_method_select = m;
    pos_start = 1;
    tick(1);
    pos_start = 0;
    tick(1);
  endtask
  task dog; dog_pin = 1; tick(10); dog_pin = 0; tick(10); endtask
  task zero; zero_pin = 1; tick(3); zero_pin = 0; tick(5); endtask
  function logic cnd(input int s);
    case (s)
      0: cnd = busy === 1'b0;
      1: cnd = reverse_turn === 1'b1;
      default: cnd = error_code === `MHR_ERR_NO_ZERO;
    endcase
  endfunction
  // Bounded wait for idle, reverse turn or error
  task wt(input int s);
    for (int i = 0; i < 300 && !cnd(s); i++) tick(1);
    chk("wait", 1, cnd(s));
  endtask
  task final_report;
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Home is missed on the first pass in the method two run, so the reverse-turn retry is needed
  initial begin
    tick(16);
    rst = 0;
    chk("status", `MHR_RST_STATUS, axis_status_word);
    start_number_command = 16'h2328;
    go(1);
    chk("busy", 0, busy);
    start_number_command = `MHR_START_HOME;
    go(1);
    chk("dir", 1, move_dir);
    zero();
    dog();
    zero();
    wt(0);
    chk("cur", home_address_setting, current_feed_monitor);
    chk("mach", home_address_setting, machine_feed_monitor);
    chk("habs", home_address_setting, home_absolute_position_monitor);
    chk("req", 0, axis_status_word[3]);
    chk("cmp", 1, axis_status_word[4]);
    addr_change_stb = 1;
    tick(1);
    addr_change_stb = 0;
    tick(1);
    chk("trk", 32'h1244, home_absolute_position_monitor);
    // Dog passed with no zero point
    go(1);
    dog();
    wt(2);
    wt(0);
    go(2);
    dog();
    wt(1);
    chk("rdir", 0, move_dir);
    tick(12);
    chk("fdir", 1, move_dir);
    chk("fspd", home_return_speed, move_speed);
    dog();
    zero();
    wt(0);
    chk("err", `MHR_ERR_NONE, error_code);
    chk("cur2", home_address_setting, current_feed_monitor);
    for (int m = 3; m < 6; m++) begin
      // A data-setting run first, so the last error code is cleared
      go(6);
      tick(2);
      chk("abs0", abs_detect_address, current_feed_monitor);
      go(3'(m));
      tick(2);
      chk("meth", `MHR_ERR_METHOD, error_code);
      chk("stay", 0, busy);
    end
    go(6);
    tick(2);
    chk("abs", abs_detect_address, current_feed_monitor);
    chk("abs1", abs_detect_address, machine_feed_monitor);
    chk("abs2", abs_detect_address, home_absolute_position_monitor);
    // Held clock enable must swallow an address shift
    clk_en = 0;
    addr_change_stb = 1;
    tick(1);
    clk_en = 1;
    addr_change_stb = 0;
    tick(1);
    chk("frz", abs_detect_address, home_absolute_position_monitor);
    final_report;
  end
endmodule
